//--- common/sim_uart_pkg.sv
// Package with register map, field positions, reset values, bus carrier and state types for the SIM-mode UART
// Functional notes
// - Frame is start, eight data, optional parity, one stop
// - Direct transmit sends byte LSB first, even parity
// - Direct receive fills from bit 0, even parity check
// - Inverse transmit inverts byte, MSB first, odd parity
// - Inverse receive inverts, fills from bit 7, odd
// - Bit rate is source over 16 times (m+1)
// - Prescaler field gives no division or 2^n
// - Clear-to-send and request-to-send have no effect
// - Transmit starts when enabled and buffer holds data
// - Receive starts when enabled and start bit seen
// - Transmit request when the last bit leaves
// - Receive request when character reaches receive buffer
// - Overrun when eighth bit arrives before buffer read
// - On overrun no receive request for that character
// - Framing error on missing stop, parity on mismatch
// - Error summary is OR of three error flags
// - Parity error with signalling enabled pulls transmit low
// - Buffer read during signal clears parity flag, releases
package sim_uart_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFF_TX_BUFFER = 8'h00;
  localparam logic [7:0] OFF_RX_BUFFER = 8'h04;
  localparam logic [7:0] OFF_BAUD_DIVIDER = 8'h08;
  localparam logic [7:0] OFF_SERIAL_MODE = 8'h0c;
  localparam logic [7:0] OFF_SERIAL_CTRL0 = 8'h10;
  localparam logic [7:0] OFF_SERIAL_CTRL1 = 8'h14;
  localparam logic [7:0] OFF_CLOCK_PRESCALE = 8'h18;
  // serial_mode_reg fields
  localparam int MODE_FIELD_LSB = 0;
  localparam int MODE_CLK_SOURCE = 3;
  localparam int MODE_PARITY_SENSE = 5;
  localparam int MODE_PARITY_EN = 6;
  // serial_ctrl0_reg fields
  localparam int C0_COUNT_SRC_LSB = 0;
  localparam int C0_SHIFT_EMPTY = 3;
  localparam int C0_FLOW_DISABLE = 4;
  localparam int C0_OPEN_DRAIN = 5;
  localparam int C0_BIT_ORDER = 7;
  // serial_ctrl1_reg fields
  localparam int C1_TX_ENABLE = 0;
  localparam int C1_TX_EMPTY = 1;
  localparam int C1_RX_ENABLE = 2;
  localparam int C1_RX_DONE = 3;
  localparam int C1_TX_IRQ_SEL = 4;
  localparam int C1_INVERT = 6;
  localparam int C1_ERR_SIGNAL = 7;
  // rx_buffer_reg flag positions above the data byte
  localparam int RB_OVERRUN = 12;
  localparam int RB_FRAME = 13;
  localparam int RB_PARITY = 14;
  localparam int RB_SUM = 15;
  // Writable masks and reset values
  localparam logic [7:0] CTRL0_WR_MASK = 8'hb3;
  localparam logic [7:0] CTRL1_WR_MASK = 8'hd5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL0_RST = 8'h10;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  // Count source codes
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_F2N = 2'h2;
  localparam logic [2:0] F8_LAST = 3'h7;
  // Oversampling: 16 ticks per bit, sample in the middle
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [2:0] DATA_LAST = 3'h7;
  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  // Line state machines
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : sim_uart_pkg

//--- rtl/sim_uart_baud.sv
// Bit-rate generator giving the 16x oversampling tick
`timescale 1ns/1ps
module sim_uart_baud
  import sim_uart_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [3:0] prescale_i,
  input wire logic [7:0] divider_i,
  output logic tick_o
);
  logic [14:0] pre_cnt_q; // Prescaler counter for the 2^n source
  logic [2:0] f8_cnt_q; // Divide-by-8 counter
  logic [7:0] div_cnt_q; // Down counter of the baud divider
  logic src_tick_w; // One pulse per selected source clock
  logic pre_end_w;
  // 2^n - 1 is the terminal count; n = 0 gives a pulse every cycle
  assign pre_end_w = (pre_cnt_q == ((15'h0001 << prescale_i) - 15'h0001));
  always_comb
  begin
    case (src_sel_i)
      SRC_F1: src_tick_w = 1'b1;
      SRC_F8: src_tick_w = (f8_cnt_q == F8_LAST);
      SRC_F2N: src_tick_w = pre_end_w;
      default: src_tick_w = 1'b1;
    endcase
  end
  // Source prescalers run freely
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_cnt_q <= 15'h0000;
      f8_cnt_q <= 3'h0;
    end
    else if (clk_en_i)
    begin
      f8_cnt_q <= f8_cnt_q + 3'h1;
      pre_cnt_q <= pre_end_w ? 15'h0000 : pre_cnt_q + 15'h0001;
    end
  end
  // Divide by m+1; the tick is 16x the bit rate
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      tick_o <= 1'b0;
      if (src_tick_w)
      begin
        if (div_cnt_q == 8'h00)
        begin
          div_cnt_q <= divider_i;
          tick_o <= 1'b1;
        end
        else
        begin
          div_cnt_q <= div_cnt_q - 8'h01;
        end
      end
    end
  end
endmodule : sim_uart_baud

//--- rtl/sim_uart.sv
// SIM-mode asynchronous serial channel with APB register slave
`timescale 1ns/1ps
module sim_uart
  import sim_uart_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input sim_uart_pkg::apb_req_t apb_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);
  import sim_uart_pkg::*;

  logic [7:0] tx_buf_q; // Transmit buffer
  logic tx_empty_q; // Transmit buffer empty flag
  logic [7:0] rx_buf_q; // Receive buffer
  logic rx_done_q; // Receive complete flag
  logic [7:0] baud_q; // Baud divider value m
  logic [7:0] mode_q; // Mode register
  logic [7:0] ctrl0_q; // Control 0
  logic [7:0] ctrl1_q; // Control 1
  logic [3:0] presc_q; // Prescale field
  logic ovr_q; // Overrun flag
  logic fer_q; // Framing flag
  logic per_q; // Parity flag
  logic err_sig_q; // Error indication on the transmit pin
  logic [3:0] err_cnt_q; // Ticks of the error indication
  logic tick_w; // 16x oversampling tick
  // Decoded configuration
  logic par_sense_w, par_en_w, msb_first_w, invert_w, tx_en_w, rx_en_w, err_en_w, irq_sel_w;
  assign par_sense_w = mode_q[MODE_PARITY_SENSE];
  assign par_en_w = mode_q[MODE_PARITY_EN];
  assign msb_first_w = ctrl0_q[C0_BIT_ORDER];
  assign invert_w = ctrl1_q[C1_INVERT];
  assign tx_en_w = ctrl1_q[C1_TX_ENABLE];
  assign rx_en_w = ctrl1_q[C1_RX_ENABLE];
  assign err_en_w = ctrl1_q[C1_ERR_SIGNAL];
  assign irq_sel_w = ctrl1_q[C1_TX_IRQ_SEL];

  // Bus decode; every access takes one wait state so read data comes from a flop
  logic acc_w, done_w, hit_w, wr_w, rd_rx_w;
  assign acc_w = apb_req_i.psel && apb_req_i.penable;
  assign done_w = acc_w && pready_o;
  assign hit_w = (apb_req_i.paddr == OFF_TX_BUFFER) || (apb_req_i.paddr == OFF_RX_BUFFER) ||
                 (apb_req_i.paddr == OFF_BAUD_DIVIDER) || (apb_req_i.paddr == OFF_SERIAL_MODE) ||
                 (apb_req_i.paddr == OFF_SERIAL_CTRL0) || (apb_req_i.paddr == OFF_SERIAL_CTRL1) ||
                 (apb_req_i.paddr == OFF_CLOCK_PRESCALE);
  assign wr_w = done_w && apb_req_i.pwrite && hit_w;
  assign rd_rx_w = done_w && !apb_req_i.pwrite && (apb_req_i.paddr == OFF_RX_BUFFER);

  sim_uart_baud u_baud (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .src_sel_i(ctrl0_q[C0_COUNT_SRC_LSB +: 2]),
    .prescale_i(presc_q),
    .divider_i(baud_q),
    .tick_o(tick_w)
  );

  // Transmitter
  tx_state_t tx_st_q;
  logic [3:0] tx_os_q; // Tick within the bit
  logic [2:0] tx_cnt_q; // Data bit index
  logic [7:0] tx_sh_q; // Shift register
  logic tx_par_q; // Parity bit to send
  logic tx_done_q; // Last bit has left
  logic tx_load_w, tx_bit_w;
  logic [7:0] tx_byte_w;
  // No handshake term: clear-to-send is ignored in this mode
  assign tx_load_w = (tx_st_q == TX_IDLE) && tx_en_w && !tx_empty_q;
  assign tx_byte_w = invert_w ? ~tx_buf_q : tx_buf_q;
  // Line level from the state; idle and stop are high
  always_comb
  begin
    case (tx_st_q)
      TX_START: tx_bit_w = 1'b0;
      TX_DATA: tx_bit_w = msb_first_w ? tx_sh_q[7] : tx_sh_q[0];
      TX_PAR: tx_bit_w = tx_par_q;
      default: tx_bit_w = 1'b1;
    endcase
  end
  // Frame sequencing: start, eight data, optional parity, one stop
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_st_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      tx_cnt_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      tx_done_q <= 1'b0;
      if (tx_load_w)
      begin
        tx_st_q <= TX_START;
        tx_os_q <= 4'h0;
        tx_cnt_q <= 3'h0;
        tx_sh_q <= tx_byte_w;
        // Even parity when the sense bit is set, odd otherwise
        tx_par_q <= (^tx_byte_w) ^ ~par_sense_w;
      end
      else if (tick_w && (tx_st_q != TX_IDLE))
      begin
        tx_os_q <= tx_os_q + 4'h1;
        if (tx_os_q == OS_LAST)
        begin
          case (tx_st_q)
            TX_START: tx_st_q <= TX_DATA;
            TX_DATA:
            begin
              tx_sh_q <= msb_first_w ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};
              tx_cnt_q <= tx_cnt_q + 3'h1;
              if (tx_cnt_q == DATA_LAST)
              begin
                tx_st_q <= par_en_w ? TX_PAR : TX_STOP;
              end
            end
            TX_PAR: tx_st_q <= TX_STOP;
            TX_STOP:
            begin
              tx_st_q <= TX_IDLE;
              tx_done_q <= 1'b1;
            end
            default: tx_st_q <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // Receiver
  rx_state_t rx_st_q;
  logic [3:0] rx_os_q;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_sh_q; // Receive shift register
  logic rx_par_q; // Running parity of line bits
  logic rx_ovr_char_q; // This character overran the buffer
  logic mid_w, rx_end_w, per_set_w, fer_set_w, ovr_set_w, rx_irq_w;
  logic rx_val_w;
  assign mid_w = tick_w && (rx_os_q == OS_MID);
  assign rx_val_w = rxd_i ^ invert_w;
  assign rx_end_w = (rx_st_q == RX_STOP) && mid_w;
  assign fer_set_w = rx_end_w && !rxd_i;
  assign per_set_w = rx_end_w && par_en_w && (rx_par_q ^ ~par_sense_w);
  assign ovr_set_w = (rx_st_q == RX_DATA) && mid_w && (rx_cnt_q == DATA_LAST) && rx_done_q;
  assign rx_irq_w = rx_end_w && !rx_ovr_char_q;
  // Character sequencing, sampled mid-bit
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_st_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_ovr_char_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (rx_st_q == RX_IDLE)
      begin
        if (rx_en_w && !rxd_i)
        begin
          rx_st_q <= RX_START;
          rx_os_q <= 4'h0;
          rx_cnt_q <= 3'h0;
          rx_par_q <= 1'b0;
          rx_ovr_char_q <= 1'b0;
        end
      end
      else if (tick_w)
      begin
        rx_os_q <= rx_os_q + 4'h1;
        case (rx_st_q)
          RX_START:
          begin
            // A start that is high again mid-bit was a glitch
            if (mid_w && rxd_i)
            begin
              rx_st_q <= RX_IDLE;
            end
            else if (rx_os_q == OS_LAST)
            begin
              rx_st_q <= RX_DATA;
            end
          end
          RX_DATA:
          begin
            if (mid_w)
            begin
              rx_sh_q <= msb_first_w ? {rx_sh_q[6:0], rx_val_w} : {rx_val_w, rx_sh_q[7:1]};
              rx_par_q <= rx_par_q ^ rxd_i;
              if (ovr_set_w)
              begin
                rx_ovr_char_q <= 1'b1;
              end
            end
            if (rx_os_q == OS_LAST)
            begin
              rx_cnt_q <= rx_cnt_q + 3'h1;
              if (rx_cnt_q == DATA_LAST)
              begin
                rx_st_q <= par_en_w ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR:
          begin
            if (mid_w)
            begin
              rx_par_q <= rx_par_q ^ rxd_i;
            end
            if (rx_os_q == OS_LAST)
            begin
              rx_st_q <= RX_STOP;
            end
          end
          // Back to idle at the stop sample so the next start edge is not missed
          RX_STOP:
          begin
            if (mid_w)
            begin
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer load; an overrun character still lands, overwriting the unread character
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_buf_q <= 8'h00;
      rx_done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (rx_end_w)
      begin
        rx_buf_q <= rx_sh_q;
      end
      // Set wins over the clearing read
      if (rx_irq_w)
      begin
        rx_done_q <= 1'b1;
      end
      else if (rd_rx_w)
      begin
        rx_done_q <= 1'b0;
      end
    end
  end

  // Error flags: set wins; disabling the receiver clears them
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovr_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ovr_q <= ovr_set_w || (ovr_q && rx_en_w);
      fer_q <= fer_set_w || (fer_q && rx_en_w);
      per_q <= per_set_w || (per_q && rx_en_w && !(rd_rx_w && err_sig_q));
    end
  end

  // Error indication: one bit time of low, cut short by a buffer read
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_sig_q <= 1'b0;
      err_cnt_q <= 4'h0;
    end
    else if (clk_en_i)
    begin
      if (per_set_w && err_en_w)
      begin
        err_sig_q <= 1'b1;
        err_cnt_q <= 4'h0;
      end
      else if (rd_rx_w)
      begin
        err_sig_q <= 1'b0;
      end
      else if (err_sig_q && tick_w)
      begin
        err_cnt_q <= err_cnt_q + 4'h1;
        if (err_cnt_q == OS_LAST)
        begin
          err_sig_q <= 1'b0;
        end
      end
    end
  end

  // Pin and request outputs, all registered
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      txd_o <= tx_bit_w && !err_sig_q;
      // Open drain drives only the low level; the card side pull-up makes high
      txd_oe_o <= ctrl0_q[C0_OPEN_DRAIN] ? !(tx_bit_w && !err_sig_q) : 1'b1;
      tx_irq_o <= irq_sel_w ? tx_done_q : tx_load_w;
      rx_irq_o <= rx_irq_w;
    end
  end

  // Register writes and transmit buffer flag; a write beats a same-cycle load
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_buf_q <= 8'h00;
      tx_empty_q <= 1'b1;
      baud_q <= BAUD_RST;
      mode_q <= MODE_RST;
      ctrl0_q <= CTRL0_RST;
      ctrl1_q <= CTRL1_RST;
      presc_q <= PRESCALE_RST[3:0];
    end
    else if (clk_en_i)
    begin
      if (tx_load_w)
      begin
        tx_empty_q <= 1'b1;
      end
      if (wr_w)
      begin
        case (apb_req_i.paddr)
          OFF_TX_BUFFER:
          begin
            tx_buf_q <= apb_req_i.pwdata[7:0];
            tx_empty_q <= 1'b0;
          end
          OFF_BAUD_DIVIDER: baud_q <= apb_req_i.pwdata[7:0];
          OFF_SERIAL_MODE: mode_q <= apb_req_i.pwdata[7:0];
          OFF_SERIAL_CTRL0: ctrl0_q <= apb_req_i.pwdata[7:0] & CTRL0_WR_MASK;
          OFF_SERIAL_CTRL1: ctrl1_q <= apb_req_i.pwdata[7:0] & CTRL1_WR_MASK;
          OFF_CLOCK_PRESCALE: presc_q <= apb_req_i.pwdata[3:0];
          default: presc_q <= presc_q;
        endcase
      end
    end
  end

  // Read mux with live status bits
  logic [31:0] rdata_w;
  always_comb
  begin
    rdata_w = 32'h0000_0000;
    case (apb_req_i.paddr)
      OFF_TX_BUFFER: rdata_w[7:0] = tx_buf_q;
      OFF_RX_BUFFER:
      begin
        rdata_w[7:0] = rx_buf_q;
        rdata_w[RB_OVERRUN] = ovr_q;
        rdata_w[RB_FRAME] = fer_q;
        rdata_w[RB_PARITY] = per_q;
        rdata_w[RB_SUM] = ovr_q || fer_q || per_q;
      end
      OFF_BAUD_DIVIDER: rdata_w[7:0] = baud_q;
      OFF_SERIAL_MODE: rdata_w[7:0] = mode_q;
      OFF_SERIAL_CTRL0:
      begin
        rdata_w[7:0] = ctrl0_q;
        rdata_w[C0_SHIFT_EMPTY] = (tx_st_q == TX_IDLE);
      end
      OFF_SERIAL_CTRL1:
      begin
        rdata_w[7:0] = ctrl1_q;
        rdata_w[C1_TX_EMPTY] = tx_empty_q;
        rdata_w[C1_RX_DONE] = rx_done_q;
      end
      OFF_CLOCK_PRESCALE: rdata_w[3:0] = presc_q;
      default: rdata_w = 32'h0000_0000;
    endcase
  end
  // APB answer one cycle into the access phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pready_o <= acc_w && !pready_o;
      pslverr_o <= acc_w && !pready_o && !hit_w;
      if (acc_w && !pready_o)
      begin
        prdata_o <= apb_req_i.pwrite ? 32'h0000_0000 : rdata_w;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_err_begin;
    $rose(err_sig_q);
  endsequence
  sequence s_rx_clear_read;
    rd_rx_w && err_sig_q && !per_set_w && clk_en_i;
  endsequence
  a_tx_start_cond: assert property ($rose(tx_st_q == TX_START) |-> $past(tx_en_w && !tx_empty_q))
    else $error("transmit started without enable or data");
  a_tx_irq_done: assert property ((clk_en_i && tx_done_q && irq_sel_w) |=> tx_irq_o)
    else $error("no transmit request after last bit");
  a_rx_start_cond: assert property ($rose(rx_st_q == RX_START) |-> $past(rx_en_w && !rxd_i))
    else $error("receive started without enable or start bit");
  a_rx_no_irq_ovr: assert property ((clk_en_i && rx_end_w && rx_ovr_char_q) |=> !rx_irq_o)
    else $error("receive request raised on overrun");
  a_ovr_needs_full: assert property ($rose(ovr_q) |-> $past(rx_done_q))
    else $error("overrun without unread buffer");
  a_sum_reads_back: assert property ((clk_en_i && acc_w && !pready_o && !apb_req_i.pwrite &&
      apb_req_i.paddr == OFF_RX_BUFFER && (ovr_q || fer_q || per_q)) |=> prdata_o[RB_SUM])
    else $error("error summary not shown");
  a_err_drives_low: assert property ((clk_en_i && err_sig_q) |=> !txd_o && txd_oe_o)
    else $error("error indication not on transmit pin");
  a_err_cause: assert property (s_err_begin |-> $past(per_set_w && err_en_w))
    else $error("error indication without parity error");
  a_read_clears: assert property (s_rx_clear_read |=> !per_q && !err_sig_q)
    else $error("buffer read did not end error indication");
  a_err_min_len: assert property (s_err_begin ##0 (!rd_rx_w)[*2] |-> err_sig_q[*2])
    else $error("error indication too short");
endmodule : sim_uart

//--- tb/sim_card.sv
// Behavioural smart-card model on the far side of the serial pins
`timescale 1ns/1ps
module sim_card
(
  input wire logic ref_clk_i,
  input wire logic line_i,
  output logic rxd_o
);
  // Pull-up keeps the idle line high
  initial rxd_o = 1'b1;
  // Send one frame, start bit first, each bit held bitlen clocks
  task automatic send(input logic [10:0] f, input int bitlen);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge ref_clk_i) rxd_o <= f[i];
      repeat (bitlen - 1) @(posedge ref_clk_i);
    end
    // A broken stop bit must not leave the line low
    @(posedge ref_clk_i) rxd_o <= 1'b1;
  endtask : send
  // Capture one frame at mid-bit; a silent line gives up after a bound
  task automatic get(input int bitlen, output logic [10:0] f);
    int n;
    n = 0;
    f = '1;
    while (line_i !== 1'b0 && n < 2000)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (bitlen / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = line_i;
      repeat (bitlen) @(posedge ref_clk_i);
    end
  endtask : get
endmodule : sim_card

//--- tb/sim_card_uart_mode_tb.sv
// Self-checking bench for the SIM-mode serial channel
`timescale 1ns/1ps
module sim_card_uart_mode_tb;
  import sim_uart_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  apb_req_t req = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rxd, txd_o, txd_oe_o, tx_irq_o, rx_irq_o, line;
  logic [10:0] f;
  logic [31:0] r;
  logic e;
  int err_total = 0, checked = 0, cyc = 0, txp = 0, rxp = 0, n;
  // Free-running clock, 25 ns period
  always #12.5 ref_clk_i = ~ref_clk_i;
  // Open-drain style wire with pull-up
  assign line = !(txd_oe_o && !txd_o);
  sim_uart dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .apb_req_i(req),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd), .txd_o(txd_o),
    .txd_oe_o(txd_oe_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
  sim_card card (.ref_clk_i(ref_clk_i), .line_i(line), .rxd_o(rxd));
  // Pulse counters and hang guard
  always @(posedge ref_clk_i)
  begin
    cyc++;
    txp += (tx_irq_o === 1'b1);
    rxp += (rx_irq_o === 1'b1);
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // One APB transfer; waits for pready as long as it takes, only the hang guard ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i) req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    req <= '0;
  endtask : apb
  // Line image of a character; both formats give d back on receive
  function automatic logic [10:0] frm(input logic [7:0] d, input logic inv);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) b[i] = inv ? ~d[7-i] : d[i];
    return {1'b1, inv ? ~^b : ^b, b, 1'b0};
  endfunction : frm
  task automatic t_regs;
    // Shift-empty status reads 1 while the transmitter is idle
    apb(0, OFF_SERIAL_CTRL0, 0);
    chk(r, 32'h18);
    apb(0, OFF_SERIAL_CTRL1, 0);
    chk(r, 32'h02);
    apb(1, OFF_SERIAL_CTRL0, 32'hff);
    apb(0, OFF_SERIAL_CTRL0, 0);
    chk(r, 32'hbb);
    apb(0, 8'h1c, 0);
    chk({31'h0, e}, 32'h1);
    apb(1, OFF_SERIAL_CTRL0, 32'h10);
  endtask : t_regs
  // Direct transmit at m=1; held back until enabled
  task automatic t_tx_direct;
    apb(1, OFF_BAUD_DIVIDER, 32'h1);
    apb(1, OFF_SERIAL_MODE, 32'h60);
    apb(1, OFF_TX_BUFFER, 32'ha5);
    repeat (40) @(posedge ref_clk_i);
    chk(line, 1);
    n = txp;
    apb(1, OFF_SERIAL_CTRL1, 32'h11);
    card.get(32, f);
    chk(f, frm(8'ha5, 0));
    repeat (8) @(posedge ref_clk_i);
    chk(txp - n, 1);
    apb(1, OFF_BAUD_DIVIDER, 32'h0);
  endtask : t_tx_direct
  task automatic t_tx_inverse;
    apb(1, OFF_SERIAL_CTRL0, 32'h90);
    apb(1, OFF_SERIAL_MODE, 32'h40);
    // Inversion lives in control 1; keep transmit enabled and completion requests
    apb(1, OFF_SERIAL_CTRL1, 32'h51);
    apb(1, OFF_TX_BUFFER, 32'h3c);
    card.get(16, f);
    chk(f, frm(8'h3c, 1));
  endtask : t_tx_inverse
  // Inverse receive with bad parity and the low error signal
  task automatic t_err_signal;
    apb(1, OFF_SERIAL_CTRL1, 32'hc4);
    card.send(frm(8'h96, 1) ^ 11'h200, 16);
    chk(txd_o, 0);
    // Card-side view of the shared line shows the card being told of the error
    chk(line, 0);
    apb(0, OFF_RX_BUFFER, 0);
    chk(r, 32'hc096);
    // Registered pin follows the clearing edge one cycle later, well before the natural end
    repeat (2) @(posedge ref_clk_i);
    chk(txd_o, 1);
    apb(0, OFF_RX_BUFFER, 0);
    chk(r[14], 0);
  endtask : t_err_signal
  // Disabled receive, direct receive, overrun, then a broken stop bit
  task automatic t_rx_direct;
    apb(1, OFF_SERIAL_CTRL0, 32'h10);
    apb(1, OFF_SERIAL_MODE, 32'h60);
    apb(1, OFF_SERIAL_CTRL1, 32'h00);
    n = rxp;
    card.send(frm(8'h5a, 0), 16);
    chk(rxp - n, 0);
    apb(1, OFF_SERIAL_CTRL1, 32'h04);
    card.send(frm(8'h5a, 0), 16);
    chk(rxp - n, 1);
    apb(0, OFF_RX_BUFFER, 0);
    chk(r, 32'h5a);
    card.send(frm(8'h11, 0), 16);
    card.send(frm(8'h22, 0), 16);
    chk(rxp - n, 2);
    apb(0, OFF_RX_BUFFER, 0);
    chk(r[15:12], 4'h9);
    apb(1, OFF_SERIAL_CTRL1, 32'h00);
    apb(1, OFF_SERIAL_CTRL1, 32'h04);
    card.send(frm(8'h77, 0) ^ 11'h400, 16);
    apb(0, OFF_RX_BUFFER, 0);
    chk(r[15:12], 4'ha);
  endtask : t_rx_direct
  task automatic results;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // Main sequence after 20 cycles of reset; clock source stays internal
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_tx_direct();
    t_tx_inverse();
    t_err_signal();
    t_rx_direct();
    results();
  end
endmodule : sim_card_uart_mode_tb
